// ### core/bfs_top.sv
// breaker failure supervisor: inputs, criteria, registers and interrupt
//
// Notes on behaviour
// [R01] initiation from internal trip and external input
// [R02] separate pickup, timer, trip per source
// [R03] both sources share threshold and delay
// [R04] current-only mode ignores auxiliary contacts
// [R05] current flow: any phase above threshold
// [R06] contact evaluation follows wired contact set
// [R07] breaker position tracked before any initiation
// [R08] initiation raises pickup and starts timer
// [R09] timer expiry with pickup gives source trip
// [R10] function switchable and blocked by input
// [R11] pickup optionally routed to breaker retrip
// [R12] criterion lost before expiry: reset, no trip
// [R13] external initiate must hold whole delay
// [R14] voltage initiators should use contact position
// [R15] switch: current plus contacts, or current
// [R16] a-contact open when breaker open, b reverse
// [R17] delay 0.06 to 60 s, default 0.25
// [R18] delay counted in prescaled whole milliseconds
`timescale 1ns/1ps
`default_nettype none
module bfs_top
  import bfs_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES,
  parameter int CW = CUR_W
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [CW-1:0] phase_a_current,
  input wire logic [CW-1:0] phase_b_current,
  input wire logic [CW-1:0] phase_c_current,
  input wire logic trip_initiate_int,
  input wire logic bf_external_initiate,
  input wire logic bf_block_input,
  input wire logic aux_contact_a,
  input wire logic aux_contact_b,
  output logic bf_pickup_alarm_int,
  output logic bf_pickup_alarm_ext,
  output logic bf_pickup_alarm,
  output logic bf_trip_out_int,
  output logic bf_trip_out_ext,
  output logic bf_trip_out,
  output logic bf_retrip_route,
  output logic irq
);

  // -------------------------------------------------------------------
  // elaboration checks
  // -------------------------------------------------------------------
  if (MS_CYCLES_P < 2 || CW < 1 || CW > 16) begin : g_chk
    $error("bfs_top: MS_CYCLES_P or CW out of range");
  end

  localparam int PW = $clog2(MS_CYCLES_P + 1);
  localparam logic [PW-1:0] PRESC_LAST = PW'(MS_CYCLES_P - 1);

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [3:0] pin_meta, pin_sync;
  logic ext_init_s, block_s, aux_a_s, aux_b_s;

  // two flops on each of the four single-bit external pins; only the second stage is read
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {aux_contact_b, aux_contact_a, bf_block_input,
                   bf_external_initiate};
      pin_sync <= pin_meta;
    end
  end

  assign ext_init_s = pin_sync[0];
  assign block_s = pin_sync[1];
  assign aux_a_s = pin_sync[2];
  assign aux_b_s = pin_sync[3];

  // -------------------------------------------------------------------
  // millisecond prescaler
  // -------------------------------------------------------------------
  logic [PW-1:0] presc;
  logic ms_tick;

  assign ms_tick = (presc == PRESC_LAST); // [R18]

  // free running, so the first tick of a delay may come early
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      presc <= '0;
    end else begin
      presc <= ms_tick ? '0 : presc + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  // -------------------------------------------------------------------
  // settings registers
  // -------------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic [CW-1:0] cur_thr;
  logic [DELAY_W-1:0] delay_ms;
  logic [IRQ_W-1:0] irq_stat, irq_mask;
  logic ctrl_en, ctrl_aux, ctrl_rti, ctrl_rte;
  bfs_wire_t wiring;

  assign ctrl_en = ctrl[CTRL_EN_BIT];
  assign ctrl_aux = ctrl[CTRL_AUX_BIT];
  assign ctrl_rti = ctrl[CTRL_RTI_BIT];
  assign ctrl_rte = ctrl[CTRL_RTE_BIT];
  assign wiring = bfs_wire_t'(ctrl[CTRL_WIRE_LSB +: 2]);

  // -------------------------------------------------------------------
  // breaker position criteria
  // -------------------------------------------------------------------
  logic cur_flow, aux_closed, crit, active, blocked;

  // any single phase above the one shared threshold
  assign cur_flow = (phase_a_current > cur_thr) |
                    (phase_b_current > cur_thr) |
                    (phase_c_current > cur_thr); // [R05] [R03]

  // a reads closed with the breaker closed, b reads open then;
  // with both wired either one showing closed keeps the breaker closed
  assign aux_closed = (wiring == WIRE_BOTH) ? (aux_a_s | ~aux_b_s) :
                      (wiring == WIRE_A_ONLY) ? aux_a_s :
                      (wiring == WIRE_B_ONLY) ? ~aux_b_s :
                      1'b0; // [R06] [R16] [R07]

  // contacts join in only when selected; voltage initiators need them
  assign crit = ctrl_aux ? (cur_flow | aux_closed) : cur_flow; // [R04] [R15]

  assign active = ctrl_en & ~block_s; // [R10]
  assign blocked = ctrl_en & block_s;

  // -------------------------------------------------------------------
  // initiation paths
  // -------------------------------------------------------------------
  logic pu_int, pu_ext, tr_int, tr_ext;

  // internal protection trip, same clock, no synchroniser needed
  bfs_path #(.DW(DELAY_W)) u_path_int (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ms_tick(ms_tick),
    .active(active),
    .initiate(trip_initiate_int),
    .criterion(crit),
    .delay_ms(delay_ms),
    .pickup(pu_int),
    .trip(tr_int)
  ); // [R01] [R02] [R08] [R09] [R12]

  // external trip input; any gap in it restarts the timer
  bfs_path #(.DW(DELAY_W)) u_path_ext (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ms_tick(ms_tick),
    .active(active),
    .initiate(ext_init_s),
    .criterion(crit),
    .delay_ms(delay_ms),
    .pickup(pu_ext),
    .trip(tr_ext)
  ); // [R01] [R02] [R13] [R03]

  // outputs and optional retrip of the own breaker
  assign bf_pickup_alarm_int = pu_int;
  assign bf_pickup_alarm_ext = pu_ext;
  assign bf_pickup_alarm = pu_int | pu_ext;
  assign bf_trip_out_int = tr_int;
  assign bf_trip_out_ext = tr_ext;
  assign bf_trip_out = tr_int | tr_ext;
  assign bf_retrip_route = (ctrl_rti & pu_int) | (ctrl_rte & pu_ext); // [R11]

  // -------------------------------------------------------------------
  // wishbone slave
  // -------------------------------------------------------------------
  logic req, wr, rd_ok;
  logic [31:0] wmask, wval, rd_val, status;
  logic [DELAY_W-1:0] delay_clamped;
  logic [IRQ_W-1:0] events, w1c, prev_ev;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign rd_ok = ~wb_we_i;

  // merge written byte lanes into the addressed register
  assign wval = (wb_dat_i & wmask) | (
    (wb_adr_i == ADR_CTRL) ? {26'h0, ctrl} & ~wmask :
    (wb_adr_i == ADR_THR) ? {{(32-CW){1'b0}}, cur_thr} & ~wmask :
    (wb_adr_i == ADR_DELAY) ? {16'h0, delay_ms} & ~wmask :
    (wb_adr_i == ADR_IRQ_MASK) ? {28'h0, irq_mask} & ~wmask :
    32'h0);

  // out-of-range delays are clamped rather than refused
  assign delay_clamped = (wval[15:0] < DELAY_MIN_MS) ? DELAY_MIN_MS :
                         (wval[15:0] > DELAY_MAX_MS) ? DELAY_MAX_MS :
                         wval[15:0]; // [R17]

  assign status = {24'h0, blocked, active, cur_flow, crit,
                   tr_ext, tr_int, pu_ext, pu_int}; // [R07]

  assign rd_val = (wb_adr_i == ADR_CTRL) ? {26'h0, ctrl} :
                  (wb_adr_i == ADR_THR) ? {{(32-CW){1'b0}}, cur_thr} :
                  (wb_adr_i == ADR_DELAY) ? {16'h0, delay_ms} :
                  (wb_adr_i == ADR_STATUS) ? status :
                  (wb_adr_i == ADR_IRQ_STAT) ? {28'h0, irq_stat} :
                  (wb_adr_i == ADR_IRQ_MASK) ? {28'h0, irq_mask} :
                  32'h0;

  // one wait state: ack in the cycle after the request, one cycle wide
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req & rd_ok) ? rd_val : 32'h0;
    end
  end

  // settings writes; unmapped offsets are acked and ignored
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RST;
      cur_thr <= CW'(CUR_THR_RST);
      delay_ms <= DELAY_RST_MS; // [R17]
      irq_mask <= IRQ_RST;
    end else if (wr) begin
      if (wb_adr_i == ADR_CTRL) ctrl <= wval[CTRL_W-1:0]; // [R10] [R15]
      if (wb_adr_i == ADR_THR) cur_thr <= wval[CW-1:0]; // [R03]
      if (wb_adr_i == ADR_DELAY) delay_ms <= delay_clamped; // [R03]
      if (wb_adr_i == ADR_IRQ_MASK) irq_mask <= wval[IRQ_W-1:0];
    end
  end

  // -------------------------------------------------------------------
  // interrupt status
  // -------------------------------------------------------------------
  assign events = {tr_ext, tr_int, pu_ext, pu_int} & ~prev_ev;
  assign w1c = (wr && wb_adr_i == ADR_IRQ_STAT) ?
               (wb_dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]) : '0;

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_ev <= '0;
      irq_stat <= IRQ_RST;
    end else begin
      prev_ev <= {tr_ext, tr_int, pu_ext, pu_int};
      irq_stat <= (irq_stat & ~w1c) | events;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_wb_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_wb_ack;
    @(posedge sys_clk) disable iff (!rst_b)
    s_wb_req |=> s_wb_ack_pulse;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("bus ack not a single pulse after request");

  property p_pickup_start;
    @(posedge sys_clk) disable iff (!rst_b)
    (!pu_int && active && trip_initiate_int && crit) |=> pu_int;
  endproperty
  a_pickup_start: assert property (p_pickup_start) // [R08]
    else $error("internal pickup did not follow initiation");

  property p_cur_pickup;
    @(posedge sys_clk) disable iff (!rst_b)
    (!ctrl_aux && active && trip_initiate_int && !pu_int &&
     phase_c_current > cur_thr) |=> pu_int;
  endproperty
  a_cur_pickup: assert property (p_cur_pickup) // [R05]
    else $error("phase current above threshold gave no pickup");

  property p_contact_a;
    @(posedge sys_clk) disable iff (!rst_b)
    (ctrl_aux && wiring == WIRE_A_ONLY && aux_a_s && active &&
     trip_initiate_int && !pu_int) |=> pu_int;
  endproperty
  a_contact_a: assert property (p_contact_a) // [R16]
    else $error("closed a-contact gave no pickup");

  property p_crit_drop;
    @(posedge sys_clk) disable iff (!rst_b)
    (pu_int && !crit) |=> (!pu_int && !tr_int);
  endproperty
  a_crit_drop: assert property (p_crit_drop) // [R12]
    else $error("pickup held after criterion was lost");

  property p_ext_drop;
    @(posedge sys_clk) disable iff (!rst_b)
    (pu_ext && !ext_init_s) |=> (!pu_ext && !tr_ext);
  endproperty
  a_ext_drop: assert property (p_ext_drop) // [R13]
    else $error("external path held after initiate dropped");

  property p_block;
    @(posedge sys_clk) disable iff (!rst_b)
    (block_s || !ctrl_en) |=> (!pu_int && !pu_ext && !bf_trip_out);
  endproperty
  a_block: assert property (p_block) // [R10]
    else $error("function active while blocked or off");

  property p_trip_on_tick;
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(tr_int) |-> ($past(ms_tick) && $past(pu_int));
  endproperty
  a_trip_on_tick: assert property (p_trip_on_tick) // [R18]
    else $error("trip rose without a tick during pickup");

  property p_ext_trip_irq;
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(tr_ext) |=> irq_stat[ST_TR_EXT];
  endproperty
  a_ext_trip_irq: assert property (p_ext_trip_irq) // [R09]
    else $error("external trip did not set its status bit");

  property p_retrip;
    @(posedge sys_clk) disable iff (!rst_b)
    bf_retrip_route |-> ((ctrl_rti && pu_int) || (ctrl_rte && pu_ext));
  endproperty
  a_retrip: assert property (p_retrip) // [R11]
    else $error("retrip without a routed pickup");

  property p_trip_irq;
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(tr_int) |=> irq_stat[ST_TR_INT];
  endproperty
  a_trip_irq: assert property (p_trip_irq) // [R09]
    else $error("internal trip did not set its status bit");

endmodule
`default_nettype wire

// ### pkg/bfs_pkg.sv
// package: constants and types shared by the breaker failure supervisor
package bfs_pkg;

  // -------------------------------------------------------------------
  // time base
  // -------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;        // sys_clk at 125 MHz
  localparam int MS_NS = 1000000;          // one delay tick, in ns
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  // -------------------------------------------------------------------
  // setting widths, ranges and values after reset
  // -------------------------------------------------------------------
  localparam int DELAY_W = 16;
  localparam int CUR_W = 16;
  localparam logic [15:0] DELAY_MIN_MS = 16'h003c;  // 0.06 s
  localparam logic [15:0] DELAY_MAX_MS = 16'hea60;  // 60.00 s
  localparam logic [15:0] DELAY_RST_MS = 16'h00fa;  // 0.25 s
  localparam logic [15:0] CUR_THR_RST = 16'h0100;

  // -------------------------------------------------------------------
  // register offsets (byte addresses)
  // -------------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_THR = 8'h04;
  localparam logic [7:0] ADR_DELAY = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0c;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h14;

  // -------------------------------------------------------------------
  // control fields
  // -------------------------------------------------------------------
  localparam int CTRL_W = 6;
  localparam int CTRL_EN_BIT = 0;          // function on
  localparam int CTRL_AUX_BIT = 1;         // use_aux_contact_cfg
  localparam int CTRL_RTI_BIT = 2;         // retrip from internal pickup
  localparam int CTRL_RTE_BIT = 3;         // retrip from external pickup
  localparam int CTRL_WIRE_LSB = 4;        // 2-bit contact wiring
  localparam logic [5:0] CTRL_RST = 6'h00;

  // -------------------------------------------------------------------
  // status and interrupt fields
  // -------------------------------------------------------------------
  localparam int ST_PU_INT = 0;
  localparam int ST_PU_EXT = 1;
  localparam int ST_TR_INT = 2;
  localparam int ST_TR_EXT = 3;
  localparam int ST_CLOSED = 4;
  localparam int ST_CUR = 5;
  localparam int ST_ACTIVE = 6;
  localparam int ST_BLOCKED = 7;
  localparam int IRQ_W = 4;                // same order as status bits 0..3
  localparam logic [3:0] IRQ_RST = 4'h0;

  // contact wiring: both, normally-open only, normally-closed only, none
  typedef enum logic [1:0] {
    WIRE_BOTH,
    WIRE_A_ONLY,
    WIRE_B_ONLY,
    WIRE_NONE
  } bfs_wire_t;

  typedef enum logic [1:0] {
    PS_IDLE,
    PS_TIMING,
    PS_TRIPPED
  } bfs_path_st_t;

endpackage

// ### core/bfs_path.sv
// one initiation path: pickup, millisecond delay timer and trip
`timescale 1ns/1ps
`default_nettype none
module bfs_path
  import bfs_pkg::*;
#(
  parameter int DW = DELAY_W
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ms_tick,
  input wire logic active,
  input wire logic initiate,
  input wire logic criterion,
  input wire logic [DW-1:0] delay_ms,
  output logic pickup,
  output logic trip
);

  // -------------------------------------------------------------------
  // elaboration check
  // -------------------------------------------------------------------
  if (DW < 2 || DW > 31) begin : g_chk
    $error("bfs_path: DW out of range");
  end

  bfs_path_st_t state, next_state;
  logic [DW-1:0] elapsed, next_elapsed;
  logic go;
  logic [DW-1:0] elapsed_inc;

  // any loss of initiation, criterion or enable drops the path at once
  assign go = active & initiate & criterion;
  assign elapsed_inc = elapsed + {{(DW-1){1'b0}}, 1'b1};

  // next state: trip on the first tick at which elapsed reaches delay
  always_comb begin
    next_state = state;
    next_elapsed = elapsed;
    case (state)
      PS_IDLE: begin
        if (go) begin
          next_state = PS_TIMING;
          next_elapsed = '0;
        end
      end
      PS_TIMING: begin
        if (!go) begin
          next_state = PS_IDLE;
        end else if (ms_tick) begin
          next_elapsed = elapsed_inc;
          if (elapsed_inc >= delay_ms) begin
            next_state = PS_TRIPPED;
          end
        end
      end
      PS_TRIPPED: begin
        if (!go) begin
          next_state = PS_IDLE;
        end
      end
      default: begin
        next_state = PS_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= PS_IDLE;
      elapsed <= '0;
    end else begin
      state <= next_state;
      elapsed <= next_elapsed;
    end
  end

  assign pickup = (state != PS_IDLE);
  assign trip = (state == PS_TRIPPED);

endmodule
`default_nettype wire

// ### testbench/bfs_breaker_model.sv
// behavioural breaker with auxiliary contacts and external trip relay
`timescale 1ns/1ps
`default_nettype none
module bfs_breaker_model #(
  parameter int OPEN_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic trip_cmd,
  input wire logic stuck,
  input wire logic close_cmd,
  input wire logic relay_req,
  output logic aux_contact_a,
  output logic aux_contact_b,
  output logic relay_out
);
  logic closed;
  int cnt;
  // main contacts part after OPEN_CYC cycles of command, unless stuck;
  // a stuck breaker is what the supervisor exists to catch
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      closed <= 1'b1;
      cnt <= 0;
    end else if (close_cmd) begin
      closed <= 1'b1;
      cnt <= 0;
    end else if (trip_cmd && !stuck) begin
      cnt <= cnt + 1;
      if (cnt + 1 >= OPEN_CYC) closed <= 1'b0;
    end else begin
      cnt <= 0;
    end
  end
  // a-contact closed with breaker, b-contact the inverse
  assign aux_contact_a = closed;
  assign aux_contact_b = !closed;
  // relay passes its command as is, gaps included
  assign relay_out = relay_req;
endmodule
`default_nettype wire

// ### testbench/breaker_failure_supervisor_bench.sv
// self-checking bench for the breaker failure supervisor
`timescale 1ns/1ps
`default_nettype none
module breaker_failure_supervisor_bench;
  import bfs_pkg::*;
  localparam int MSC = 4;
  localparam int LIMIT = 20000;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [3:0] lanes = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack;
  logic [15:0] ia = 16'h0;
  logic [15:0] ib = 16'h0;
  logic [15:0] ic = 16'h0;
  logic init_int = 1'b0;
  logic relay_req = 1'b0;
  logic blk = 1'b0;
  logic stuck = 1'b1;
  logic close_cmd = 1'b0;
  logic aux_a, aux_b, ext_init, pu_i, pu_e, pu, tr_i, tr_e, tr, retrip, irq;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int n;

  // --------------------------------------------------------------
  // clock, design, partner, timeout
  // --------------------------------------------------------------
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  bfs_top #(.MS_CYCLES_P(MSC), .CW(16)) bfs_top_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .phase_a_current(ia),
    .phase_b_current(ib), .phase_c_current(ic),
    .trip_initiate_int(init_int), .bf_external_initiate(ext_init),
    .bf_block_input(blk), .aux_contact_a(aux_a), .aux_contact_b(aux_b),
    .bf_pickup_alarm_int(pu_i), .bf_pickup_alarm_ext(pu_e),
    .bf_pickup_alarm(pu), .bf_trip_out_int(tr_i), .bf_trip_out_ext(tr_e),
    .bf_trip_out(tr), .bf_retrip_route(retrip), .irq(irq));
  bfs_breaker_model #(.OPEN_CYC(20)) bfs_breaker_model_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .trip_cmd(tr | retrip),
    .stuck(stuck), .close_cmd(close_cmd), .relay_req(relay_req),
    .aux_contact_a(aux_a), .aux_contact_b(aux_b), .relay_out(ext_init));
  // a hang counts as a mismatch and ends the run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      report_and_stop();
    end
  end

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= lanes;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 32);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    check("bus_ack", k < 32, 1'b1);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(what, rdat, exp);
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task automatic wait_hi(ref logic s, input int lim, output int c);
    c = 0;
    while (s !== 1'b1 && c < lim) begin
      @(posedge sys_clk);
      c++;
    end
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    rd_chk("ctrl", ADR_CTRL, 32'h0);
    rd_chk("thr", ADR_THR, 32'h100);
    rd_chk("delay", ADR_DELAY, 32'hfa);
    rd_chk("mask", ADR_IRQ_MASK, 32'h0);
    // only the lowest byte lane is written, upper bytes keep their value
    lanes = 4'h1;
    wb(1'b1, ADR_THR, 32'hffffff20);
    lanes = 4'hf;
    rd_chk("thr_lane", ADR_THR, 32'h120);
    wb(1'b1, ADR_THR, 32'h100);
    wb(1'b1, 8'h18, 32'hffff);
    rd_chk("unmapped", 8'h18, 32'h0);
    wb(1'b1, ADR_DELAY, 32'h0);
    rd_chk("delay_lo", ADR_DELAY, 32'h3c);
    wb(1'b1, ADR_DELAY, 32'hffff);
    rd_chk("delay_hi", ADR_DELAY, 32'hea60);
    wb(1'b1, ADR_DELAY, 32'h3c);
    $display("test regs done");
  endtask
  // internal trip on a stuck breaker, retrip and interrupt
  task automatic t_int();
    wb(1'b1, ADR_CTRL, 32'h5);
    ib <= 16'h0101;
    init_int <= 1'b1;
    wait_hi(pu_i, 8, n);
    check("pu_int", pu_i, 1'b1);
    check("pu_ext", pu_e, 1'b0);
    check("retrip", retrip, 1'b1);
    check("pu_any", pu, 1'b1);
    wait_hi(tr_i, 400, n);
    check("trip_ms", n >= 59 * MSC && n <= 60 * MSC + 2, 1'b1);
    check("tr_ext", tr_e, 1'b0);
    check("tr_any", tr, 1'b1);
    rd_chk("irq_stat", ADR_IRQ_STAT, 32'h5);
    check("irq_masked", irq, 1'b0);
    wb(1'b1, ADR_IRQ_MASK, 32'h4);
    check("irq_on", irq, 1'b1);
    wb(1'b1, ADR_IRQ_STAT, 32'h4);
    check("irq_cleared", irq, 1'b0);
    rd_chk("irq_stat2", ADR_IRQ_STAT, 32'h1);
    init_int <= 1'b0;
    ib <= 16'h0;
    tick(3);
    check("trip_drop", tr_i, 1'b0);
    wb(1'b1, ADR_IRQ_STAT, 32'hf);
    wb(1'b1, ADR_IRQ_MASK, 32'h0);
    $display("test internal done");
  endtask
  // current must lie strictly above the threshold, any phase
  task automatic t_thr();
    wb(1'b1, ADR_CTRL, 32'h1);
    ib <= 16'h0100;
    init_int <= 1'b1;
    tick(6);
    check("pu_equal", pu_i, 1'b0);
    ic <= 16'h0101;
    tick(3);
    check("pu_above", pu_i, 1'b1);
    ia <= 16'h0200;
    ib <= 16'h0;
    ic <= 16'h0;
    tick(100);
    ia <= 16'h0;
    tick(3);
    check("pu_lost", pu_i, 1'b0);
    ia <= 16'h0200;
    wait_hi(tr_i, 400, n);
    check("restart", n >= 59 * MSC, 1'b1);
    check("restart_tr", tr_i, 1'b1);
    init_int <= 1'b0;
    ia <= 16'h0;
    tick(3);
    $display("test threshold done");
  endtask
  // external initiation with a one-cycle gap restarts its timer
  task automatic t_ext();
    wb(1'b1, ADR_CTRL, 32'h9);
    ia <= 16'h0200;
    relay_req <= 1'b1;
    wait_hi(pu_e, 8, n);
    check("pu_ext", pu_e, 1'b1);
    check("pu_int", pu_i, 1'b0);
    check("retrip_ext", retrip, 1'b1);
    tick(120);
    relay_req <= 1'b0;
    tick(1);
    relay_req <= 1'b1;
    wait_hi(tr_e, 400, n);
    check("ext_restart", n >= 59 * MSC - 4, 1'b1);
    check("tr_ext_on", tr_e, 1'b1);
    check("tr_int", tr_i, 1'b0);
    relay_req <= 1'b0;
    ia <= 16'h0;
    tick(4);
    $display("test external done");
  endtask
  // contact criterion across all wirings, then a breaker that opens
  task automatic t_aux();
    close_cmd <= 1'b1;
    tick(1);
    close_cmd <= 1'b0;
    wb(1'b1, ADR_CTRL, 32'h1);
    init_int <= 1'b1;
    tick(6);
    check("cur_only", pu_i, 1'b0);
    init_int <= 1'b0;
    for (int w = 0; w < 4; w++) begin
      wb(1'b1, ADR_CTRL, 32'h3 | (w << 4));
      tick(4);
      wb(1'b0, ADR_STATUS, 32'h0);
      check("closed_seen", rdat[ST_CLOSED], w != 3);
      init_int <= 1'b1;
      tick(4);
      check("pu_wiring", pu_i, w != 3);
      init_int <= 1'b0;
      tick(3);
    end
    wb(1'b1, ADR_CTRL, 32'h7);
    stuck <= 1'b0;
    init_int <= 1'b1;
    tick(4);
    check("closing_pu", pu_i, 1'b1);
    tick(36);
    check("opened_pu", pu_i, 1'b0);
    check("opened_tr", tr_i, 1'b0);
    init_int <= 1'b0;
    stuck <= 1'b1;
    tick(3);
    $display("test contacts done");
  endtask
  // block pin and function switch
  task automatic t_block();
    wb(1'b1, ADR_CTRL, 32'h1);
    ia <= 16'h0200;
    blk <= 1'b1;
    tick(4);
    init_int <= 1'b1;
    tick(6);
    check("blocked_pu", pu_i, 1'b0);
    wb(1'b0, ADR_STATUS, 32'h0);
    check("blocked_st", rdat[ST_BLOCKED], 1'b1);
    blk <= 1'b0;
    tick(5);
    check("unblocked_pu", pu_i, 1'b1);
    wb(1'b1, ADR_CTRL, 32'h0);
    tick(3);
    check("off_pu", pu_i, 1'b0);
    init_int <= 1'b0;
    ia <= 16'h0;
    $display("test block done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    tick(8);
    rst_b <= 1'b1;
    t_regs();
    t_int();
    t_thr();
    t_ext();
    t_aux();
    t_block();
    report_and_stop();
  end
endmodule
`default_nettype wire
